/* common/ccm_task_pkg.sv */
// Purpose: constants and carrier types for the cipher task register block
// Assumes: apb slave, 32-bit data, byte addresses
// Notes: datapath timing is modelled by simple cycle counts
package ccm_task_pkg;
  localparam logic [31:0] BASE_ADDR = 32'h4000f000;
  localparam logic [11:0] OFS_TASK_KS = 12'h000;
  localparam logic [11:0] OFS_TASK_CIPHER = 12'h004;
  localparam logic [11:0] OFS_TASK_HALT = 12'h008;
  localparam logic [11:0] OFS_TASK_RATE = 12'h00c;
  localparam logic [11:0] OFS_EV_KS = 12'h100;
  localparam logic [11:0] OFS_EV_CIPHER = 12'h104;
  localparam logic [11:0] OFS_EV_FAULT = 12'h108;
  localparam logic [11:0] OFS_LINKS = 12'h200;
  localparam logic [11:0] OFS_INT_SET = 12'h304;
  localparam logic [11:0] OFS_INT_CLR = 12'h308;
  localparam logic [11:0] OFS_TAG = 12'h400;
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_MODE = 12'h504;
  localparam logic [11:0] OFS_CNF_PTR = 12'h508;
  localparam logic [11:0] OFS_SRC_PTR = 12'h50c;
  localparam logic [11:0] OFS_DST_PTR = 12'h510;
  localparam logic [11:0] OFS_TMP_PTR = 12'h514;
  localparam logic [11:0] OFS_EXT_LEN = 12'h518;
  localparam logic [11:0] OFS_RATE_VAL = 12'h51c;
  localparam logic [11:0] OFS_STATUS = 12'h520; // own status: one-hot engine state, bit 0 set when idle
  // field positions
  localparam int MODE_SPEED_BIT = 16;
  localparam int MODE_LEN_BIT = 24;
  localparam int INT_KS_BIT = 0;
  localparam int INT_CIPHER_BIT = 1;
  localparam int INT_FAULT_BIT = 2;
  // reset values and timing counts
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam logic [7:0] KS_DEFAULT_LEN = 8'h1b;
  localparam logic [7:0] CIPHER_CYCLES = 8'h20;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_KEYSTREAM = 3'b010,
    ST_CIPHER = 3'b100
  } op_state_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  typedef struct packed {
    logic [31:0] addr;
    logic valid;
  } dma_req_t;
endpackage : ccm_task_pkg

/* rtl/ccm_task_regs.sv */
// Function
// (RULE1) registers decode at base 0x4000F000 plus listed offsets
// (RULE2) keystream task starts generation, which ends by itself
// (RULE3) writing 1 to cipher task starts cipher, ends by itself
// (RULE4) rate task copies substitute value into mode speed field
// (RULE5) extended length mode takes keystream length from its register
// (RULE6) key and nonce fetched from config structure pointer
// (RULE7) temporary area pointer addresses working storage
// (RULE8) halt aborts cipher; event flags read 1, cleared by writing 0
// (RULE9) link bit lets keystream done start cipher automatically
// (RULE10) dma stops accessing ram after done events
// (RULE11) ram contention during cipher raises fault event
// (RULE12) interrupt set writes 1 enable, 0 no effect, read shows enables
// Purpose: task, event and register interface of a ccm packet cipher
// Assumes: apb slave, one clock, datapath abstracted to counted steps
// Notes: dma address output models the pointer being accessed
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module ccm_task_regs
  import ccm_task_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // apb
  input wire ccm_task_pkg::apb_req_t APB_I,
  output ccm_task_pkg::apb_rsp_t APB_O,
  // dma side
  input wire logic DMA_CONFLICT_I,
  output ccm_task_pkg::dma_req_t DMA_O,
  // interrupt
  output logic IRQ_O
);
  import ccm_task_pkg::*;

  typedef struct packed {
    op_state_t st;
    logic [7:0] cnt;
    logic [1:0] phase;
    logic ev_ks;
    logic ev_cipher;
    logic ev_fault;
    logic link;
    logic [2:0] inten;
    logic enable;
    logic [31:0] mode;
    logic [31:0] cnf_ptr;
    logic [31:0] src_ptr;
    logic [31:0] dst_ptr;
    logic [31:0] tmp_ptr;
    logic [7:0] ext_len;
    logic [31:0] rate_val;
    logic tag_ok;
    apb_rsp_t rsp;
    dma_req_t dma;
    logic irq;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic wr;
  logic rd;
  logic hit;
  logic [11:0] ofs;
  logic wbit;
  // hardware event pulses of this cycle; a clear write must not swallow them
  logic [2:0] ev_set;

  // access decode, base match required
  // (RULE1) base address decode
  assign ofs = APB_I.paddr[11:0];
  assign hit = (APB_I.paddr[31:12] == BASE_ADDR[31:12]);
  assign wr = APB_I.psel && APB_I.penable && APB_I.pwrite && !s_r.rsp.pready;
  assign rd = APB_I.psel && APB_I.penable && !APB_I.pwrite && !s_r.rsp.pready;
  assign wbit = APB_I.pwdata[0];

  // next-state logic: bus, tasks, engine, events
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rsp.pready = 1'b0;
    s_nxt.rsp.pslverr = 1'b0;
    s_nxt.rsp.prdata = RESET_WORD;
    ev_set = 3'b000;
    // engine progress
    unique case (s_r.st)
      ST_IDLE:
      begin
        s_nxt.dma.valid = 1'b0;
      end
      ST_KEYSTREAM:
      begin
        // (RULE6) key fetch from config pointer
        s_nxt.dma.valid = 1'b1;
        s_nxt.dma.addr = (s_r.phase == 2'd0) ? s_r.cnf_ptr : s_r.tmp_ptr;
        s_nxt.phase = 2'd1;
        if (s_r.cnt == 8'h00)
        begin
          // (RULE2) ends by itself
          s_nxt.ev_ks = 1'b1;
          ev_set[INT_KS_BIT] = 1'b1;
          s_nxt.st = ST_IDLE;
          s_nxt.dma.valid = 1'b0;
          // (RULE9) link to cipher
          if (s_r.link)
          begin
            s_nxt.st = ST_CIPHER;
            s_nxt.cnt = CIPHER_CYCLES;
            s_nxt.phase = 2'd0;
          end
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end
      end
      ST_CIPHER:
      begin
        // (RULE7) working storage via temp pointer
        s_nxt.dma.valid = 1'b1;
        unique case (s_r.phase)
          2'd0: s_nxt.dma.addr = s_r.src_ptr;
          2'd1: s_nxt.dma.addr = s_r.tmp_ptr;
          default: s_nxt.dma.addr = s_r.dst_ptr;
        endcase
        s_nxt.phase = (s_r.phase == 2'd2) ? 2'd0 : s_r.phase + 2'd1;
        // (RULE11) contention fault
        if (DMA_CONFLICT_I)
        begin
          s_nxt.ev_fault = 1'b1;
          ev_set[INT_FAULT_BIT] = 1'b1;
        end
        if (s_r.cnt == 8'h00)
        begin
          // (RULE3) cipher ends by itself
          s_nxt.ev_cipher = 1'b1;
          ev_set[INT_CIPHER_BIT] = 1'b1;
          s_nxt.tag_ok = !s_r.ev_fault && !DMA_CONFLICT_I;
          s_nxt.st = ST_IDLE;
          // (RULE10) dma released at done
          s_nxt.dma.valid = 1'b0;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end
      end
      default:
      begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // register writes
    if (wr)
    begin
      s_nxt.rsp.pready = 1'b1;
      if (!hit)
      begin
        s_nxt.rsp.pslverr = 1'b1;
      end
      else
      begin
        unique case (ofs)
          OFS_TASK_KS:
          begin
            if (wbit && s_r.enable)
            begin
              // (RULE5) extended length selection
              s_nxt.st = ST_KEYSTREAM;
              s_nxt.phase = 2'd0;
              s_nxt.cnt = s_r.mode[MODE_LEN_BIT] ? s_r.ext_len : KS_DEFAULT_LEN;
            end
          end
          OFS_TASK_CIPHER:
          begin
            if (wbit && s_r.enable)
            begin
              // (RULE3) start cipher
              s_nxt.st = ST_CIPHER;
              s_nxt.phase = 2'd0;
              s_nxt.cnt = CIPHER_CYCLES;
            end
          end
          OFS_TASK_HALT:
          begin
            if (wbit)
            begin
              // (RULE8) abort, no done event
              s_nxt.st = ST_IDLE;
              s_nxt.dma.valid = 1'b0;
            end
          end
          OFS_TASK_RATE:
          begin
            if (wbit && s_r.st == ST_CIPHER)
            begin
              // (RULE4) speed field substitution
              s_nxt.mode[MODE_SPEED_BIT] = s_r.rate_val[0];
            end
          end
          // (RULE8) events cleared by writing 0, a same-cycle set wins
          // writing 1 keeps the flag; only a 0 with no new event clears it
          OFS_EV_KS: s_nxt.ev_ks = ev_set[INT_KS_BIT] | (s_r.ev_ks & wbit);
          OFS_EV_CIPHER: s_nxt.ev_cipher = ev_set[INT_CIPHER_BIT] | (s_r.ev_cipher & wbit);
          OFS_EV_FAULT: s_nxt.ev_fault = ev_set[INT_FAULT_BIT] | (s_r.ev_fault & wbit);
          OFS_LINKS: s_nxt.link = wbit;
          // (RULE12) set and clear of enables
          OFS_INT_SET: s_nxt.inten = s_r.inten | APB_I.pwdata[2:0];
          OFS_INT_CLR: s_nxt.inten = s_r.inten & ~APB_I.pwdata[2:0];
          OFS_ENABLE: s_nxt.enable = wbit;
          OFS_MODE: s_nxt.mode = APB_I.pwdata;
          OFS_CNF_PTR: s_nxt.cnf_ptr = APB_I.pwdata;
          OFS_SRC_PTR: s_nxt.src_ptr = APB_I.pwdata;
          OFS_DST_PTR: s_nxt.dst_ptr = APB_I.pwdata;
          OFS_TMP_PTR: s_nxt.tmp_ptr = APB_I.pwdata;
          OFS_EXT_LEN: s_nxt.ext_len = APB_I.pwdata[7:0];
          OFS_RATE_VAL: s_nxt.rate_val = APB_I.pwdata;
          default: s_nxt.rsp.pslverr = 1'b1;
        endcase
      end
    end
    // register reads
    if (rd)
    begin
      s_nxt.rsp.pready = 1'b1;
      if (!hit)
      begin
        s_nxt.rsp.pslverr = 1'b1;
      end
      else
      begin
        unique case (ofs)
          OFS_TASK_KS, OFS_TASK_CIPHER, OFS_TASK_HALT, OFS_TASK_RATE:
            s_nxt.rsp.prdata = RESET_WORD;
          OFS_EV_KS: s_nxt.rsp.prdata = {31'h0, s_r.ev_ks};
          OFS_EV_CIPHER: s_nxt.rsp.prdata = {31'h0, s_r.ev_cipher};
          OFS_EV_FAULT: s_nxt.rsp.prdata = {31'h0, s_r.ev_fault};
          OFS_LINKS: s_nxt.rsp.prdata = {31'h0, s_r.link};
          OFS_INT_SET, OFS_INT_CLR: s_nxt.rsp.prdata = {29'h0, s_r.inten};
          OFS_TAG: s_nxt.rsp.prdata = {31'h0, s_r.tag_ok};
          OFS_ENABLE: s_nxt.rsp.prdata = {31'h0, s_r.enable};
          OFS_MODE: s_nxt.rsp.prdata = s_r.mode;
          OFS_CNF_PTR: s_nxt.rsp.prdata = s_r.cnf_ptr;
          OFS_SRC_PTR: s_nxt.rsp.prdata = s_r.src_ptr;
          OFS_DST_PTR: s_nxt.rsp.prdata = s_r.dst_ptr;
          OFS_TMP_PTR: s_nxt.rsp.prdata = s_r.tmp_ptr;
          OFS_EXT_LEN: s_nxt.rsp.prdata = {24'h0, s_r.ext_len};
          OFS_RATE_VAL: s_nxt.rsp.prdata = s_r.rate_val;
          OFS_STATUS: s_nxt.rsp.prdata = {29'h0, s_r.st};
          default: s_nxt.rsp.pslverr = 1'b1;
        endcase
      end
    end
    // interrupt level from the settled flags
    s_nxt.irq = |({s_nxt.ev_fault, s_nxt.ev_cipher, s_nxt.ev_ks} & s_nxt.inten);
  end

  // state register; ce low freezes everything except the synchronous reset
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
    end
    else if (CE_I)
    begin
      s_r <= s_nxt;
    end
  end

  assign APB_O = s_r.rsp;
  assign DMA_O = s_r.dma;
  assign IRQ_O = s_r.irq;

  // checks: engine sequencing
  // (RULE2) keystream stops alone
  a_ks_done_idle: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE2)
    ($rose(s_r.ev_ks) && !s_r.link) |-> s_r.st == ST_IDLE)
    else $error("keystream did not stop");
  // (RULE9) link chains cipher
  a_link_start: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE9)
    ($rose(s_r.ev_ks) && $past(s_r.link) && $past(s_r.st) == ST_KEYSTREAM
     && $past(CE_I)) |-> s_r.st == ST_CIPHER)
    else $error("link did not start cipher");
  // (RULE3) cipher task starts
  a_cipher_start: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE3)
    (CE_I && wr && hit && ofs == OFS_TASK_CIPHER && wbit && s_r.enable)
    |=> s_r.st == ST_CIPHER)
    else $error("cipher task ignored");
  // (RULE8) halt aborts engine
  a_halt_idle: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE8)
    (CE_I && wr && hit && ofs == OFS_TASK_HALT && wbit) |=> s_r.st == ST_IDLE)
    else $error("halt did not abort");
  // (RULE5) extended length load
  a_ext_len: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE5)
    (CE_I && wr && hit && ofs == OFS_TASK_KS && wbit && s_r.enable && s_r.mode[MODE_LEN_BIT])
    |=> s_r.cnt == $past(s_r.ext_len))
    else $error("extended length not loaded");
  // (RULE4) speed field substitution
  a_rate_apply: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE4)
    (CE_I && wr && hit && ofs == OFS_TASK_RATE && wbit && s_r.st == ST_CIPHER)
    |=> s_r.mode[MODE_SPEED_BIT] == $past(s_r.rate_val[0]))
    else $error("rate substitute not applied");

  // checks: dma traffic
  // (RULE10) dma quiet when idle
  a_dma_quiet: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE10)
    (s_r.st == ST_IDLE && $past(s_r.st) == ST_IDLE) |-> !s_r.dma.valid)
    else $error("dma active while idle");
  // (RULE11) contention raises fault
  a_fault_set: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE11)
    (CE_I && s_r.st == ST_CIPHER && DMA_CONFLICT_I) |=> s_r.ev_fault)
    else $error("fault not raised");
  // (RULE6) key fetch address
  a_key_fetch: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE6)
    ($past(s_r.st) == ST_KEYSTREAM && $past(s_r.phase) == 2'd0 && $past(CE_I)
     && s_r.st == ST_KEYSTREAM) |-> s_r.dma.addr == $past(s_r.cnf_ptr))
    else $error("key not fetched from config pointer");
  // (RULE7) scratch area access
  a_tmp_access: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE7)
    ($past(s_r.st) == ST_CIPHER && $past(s_r.phase) == 2'd1 && $past(CE_I)
     && s_r.st == ST_CIPHER) |-> s_r.dma.addr == $past(s_r.tmp_ptr))
    else $error("temp area not accessed");

  // checks: events and interrupt
  // (RULE8) keystream flag stays until cleared
  a_event_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE8)
    (s_r.ev_ks && !(CE_I && wr && hit && ofs == OFS_EV_KS && !wbit)) |=> s_r.ev_ks)
    else $error("keystream event lost");
  // (RULE12) set write keeps enables
  a_inten_keep: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE12)
    (CE_I && wr && hit && ofs == OFS_INT_SET) |=> (s_r.inten & $past(s_r.inten))
    == $past(s_r.inten))
    else $error("set write cleared an enable");
  // (RULE12) enabled event drives irq
  a_irq_level: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // (RULE12)
    (s_r.ev_cipher && s_r.inten[INT_CIPHER_BIT]) |-> s_r.irq)
    else $error("irq low with enabled event");

  // main scenarios reached
  c_link_chain: cover property (@(posedge CLK_I) $rose(s_r.ev_cipher) && s_r.link);
  c_ks_done: cover property (@(posedge CLK_I) $rose(s_r.ev_ks));
  c_cipher_done: cover property (@(posedge CLK_I) $rose(s_r.ev_cipher));
  c_fault: cover property (@(posedge CLK_I) $rose(s_r.ev_fault));
  c_irq: cover property (@(posedge CLK_I) $rose(s_r.irq));
endmodule : ccm_task_regs
`default_nettype wire

/* tb/ram_side_model.sv */
// Purpose: ram side seen by the block dma master
// Assumes: contention is commanded by the bench
// Notes: hit flags are sticky until the bench clears them
`timescale 1ns/100ps
`default_nettype none
module ram_side_model
  import ccm_task_pkg::*;
(
  // clock and dma traffic
  input wire logic clk_i,
  input wire ccm_task_pkg::dma_req_t dma_i,
  // pointers under watch, contention command, hit clear
  input wire logic [31:0] cnf_i,
  input wire logic [31:0] tmp_i,
  input wire logic clash_i,
  input wire logic clr_i,
  // contention and seen pointers
  output logic conflict_o,
  output logic cnf_hit_o = 1'b0,
  output logic tmp_hit_o = 1'b0
);
  // other masters collide regardless of our own traffic
  assign conflict_o = clash_i;
  // note which structures the block fetched from
  always @(posedge clk_i)
  begin
    if (clr_i)
    begin
      cnf_hit_o <= 1'b0;
      tmp_hit_o <= 1'b0;
    end
    else
    begin
      if (dma_i.valid === 1'b1 && dma_i.addr === cnf_i)
        cnf_hit_o <= 1'b1;
      if (dma_i.valid === 1'b1 && dma_i.addr === tmp_i)
        tmp_hit_o <= 1'b1;
    end
  end
endmodule : ram_side_model
`default_nettype wire

/* tb/ccm_cipher_task_interface_tb.sv */
// Purpose: self-checking bench for the cipher task register block
// Assumes: one apb transfer at a time, CE_I low only between transfers
// Notes: latency windows allow for registered event and irq
`timescale 1ns/100ps
`default_nettype none
module ccm_cipher_task_interface_tb;
  import ccm_task_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clash = 1'b0;
  logic ce = 1'b1;
  logic hit_clr = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  dma_req_t dma;
  logic irq;
  logic conflict;
  logic cnf_hit;
  logic tmp_hit;
  logic err;
  logic [31:0] rd;
  logic [31:0] cnf_p = 32'h20000100;
  logic [31:0] tmp_p = 32'h20000400;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  // clock at 10 MHz
  always #50 clk = ~clk;
  ccm_task_regs i_ccm_task_regs (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .APB_I(req),
    .APB_O(rsp), .DMA_CONFLICT_I(conflict), .DMA_O(dma), .IRQ_O(irq));
  ram_side_model i_ram_side_model (.clk_i(clk), .dma_i(dma), .cnf_i(cnf_p), .tmp_i(tmp_p),
    .clash_i(clash), .clr_i(hit_clr), .conflict_o(conflict), .cnf_hit_o(cnf_hit),
    .tmp_hit_o(tmp_hit));
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // hang guard, well above the whole sequence
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // apb master: hold request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ofs, input logic [31:0] wd);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: BASE_ADDR | {20'h0, ofs}, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1)
      @(posedge clk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    apb(1'b1, ofs, d);
  endtask : wr
  task automatic rdchk(input string what, input logic [11:0] ofs, input logic [31:0] exp);
    apb(1'b0, ofs, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk
  // cycles from now until the interrupt line rises
  task automatic wait_irq(output int cnt);
    cnt = 0;
    while (irq !== 1'b1 && cnt < 200)
    begin
      @(posedge clk);
      cnt++;
    end
  endtask : wait_irq
  task automatic t_reset;
    rdchk("ev_ks", OFS_EV_KS, 32'h0);
    rdchk("links", OFS_LINKS, 32'h0);
    rdchk("int_en", OFS_INT_SET, 32'h0);
    rdchk("status", OFS_STATUS, 32'h1);
    apb(1'b0, 12'h600, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
  endtask : t_reset
  task automatic t_keystream;
    wr(OFS_ENABLE, 32'h1);
    wr(OFS_CNF_PTR, cnf_p);
    wr(OFS_TMP_PTR, tmp_p);
    wr(OFS_INT_SET, 32'h1);
    wr(OFS_TASK_KS, 32'h1);
    wait_irq(n);
    chk("ks time", 32'h1, {31'h0, n >= 27 && n <= 30});
    rdchk("ev_ks", OFS_EV_KS, 32'h1);
    rdchk("no chain", OFS_EV_CIPHER, 32'h0);
    chk("cnf fetch", 32'h1, {31'h0, cnf_hit});
    wr(OFS_EV_KS, 32'h0);
    rdchk("ev_ks clr", OFS_EV_KS, 32'h0);
    chk("irq low", 32'h0, {31'h0, irq});
  endtask : t_keystream
  task automatic t_ext;
    wr(OFS_MODE, 32'h01000000);
    wr(OFS_EXT_LEN, 32'h5);
    wr(OFS_TASK_KS, 32'h1);
    // freeze the engine ten cycles; an ignored enable lets irq rise early
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    wait_irq(n);
    chk("ext time", 32'h1, {31'h0, n >= 5 && n <= 8});
    wr(OFS_EV_KS, 32'h0);
    wr(OFS_MODE, 32'h0);
  endtask : t_ext
  task automatic t_link;
    wr(OFS_INT_SET, 32'h2);
    wr(OFS_INT_CLR, 32'h1);
    wr(OFS_LINKS, 32'h1);
    // forget earlier fetches so this run must touch the temp area itself
    hit_clr <= 1'b1;
    @(posedge clk);
    hit_clr <= 1'b0;
    wr(OFS_TASK_KS, 32'h1);
    wait_irq(n);
    chk("chain time", 32'h1, {31'h0, n >= 55 && n <= 70});
    rdchk("ev_cipher", OFS_EV_CIPHER, 32'h1);
    chk("dma idle", 32'h0, {31'h0, dma.valid});
    chk("tmp use", 32'h1, {31'h0, tmp_hit});
    rdchk("tag ok", OFS_TAG, 32'h1);
    wr(OFS_EV_KS, 32'h0);
    wr(OFS_EV_CIPHER, 32'h0);
    wr(OFS_LINKS, 32'h0);
  endtask : t_link
  task automatic t_halt_rate;
    wr(OFS_TASK_CIPHER, 32'h0);
    rdchk("bit0 zero", OFS_STATUS, 32'h1);
    wr(OFS_TASK_CIPHER, 32'h1);
    rdchk("busy", OFS_STATUS, 32'h4);
    wr(OFS_RATE_VAL, 32'h1);
    wr(OFS_TASK_RATE, 32'h1);
    rdchk("speed", OFS_MODE, 32'h00010000);
    wr(OFS_TASK_HALT, 32'h1);
    rdchk("halted", OFS_STATUS, 32'h1);
    repeat (40) @(posedge clk);
    rdchk("no done", OFS_EV_CIPHER, 32'h0);
  endtask : t_halt_rate
  task automatic t_fault_irq;
    wr(OFS_INT_SET, 32'h4);
    wr(OFS_TASK_CIPHER, 32'h1);
    clash <= 1'b1;
    repeat (3) @(posedge clk);
    clash <= 1'b0;
    rdchk("ev_fault", OFS_EV_FAULT, 32'h1);
    chk("irq high", 32'h1, {31'h0, irq});
    repeat (40) @(posedge clk);
    rdchk("tag fault", OFS_TAG, 32'h0);
    wr(OFS_INT_SET, 32'h0);
    rdchk("set zero", OFS_INT_SET, 32'h6);
    rdchk("clr view", OFS_INT_CLR, 32'h6);
    wr(OFS_INT_CLR, 32'h7);
    rdchk("masked", OFS_INT_SET, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
  endtask : t_fault_irq
  // main sequence after an 8 cycle reset
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_keystream();
    t_ext();
    t_link();
    t_halt_rate();
    t_fault_irq();
    results();
  end
endmodule : ccm_cipher_task_interface_tb
`default_nettype wire
